// >>> ais_top.sv
// Register file, AXI4-Lite slave and scaling of the three option-card inputs.
// Assumes converter samples on clk and a single AXI4-Lite master.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

// What this block does
// - Channel 1 range: 0 unipolar, 1 bipolar.
// - Channel 3 range: 0 unipolar, 1 bipolar.
// - Channel 2 range: voltage, bipolar, or 4-20 mA.
// - Channel 1 gain: level at 10 V.
// - Channel 1 bias: level at 0 V.
// - Channel 3 function only 2, 3, 14.
// - Channel 3 gain: level at 10 V.
// - Channel 3 bias: level at 0 V.
// - Channel 2 function 0 to 1F, default 3.
// - Channel 2 gain/bias at full/zero input.
module ais_top
	import ais_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int RESULT_W = 32
)
(
	input wire logic clk, // System clock, 20 MHz
	input wire logic rst, // Async reset, active high
	// AXI4-Lite write address
	input wire logic [15:0] awaddr, // Byte address
	input wire logic awvalid, // Address valid
	output logic awready, // Address taken
	// AXI4-Lite write data
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Byte strobes
	input wire logic wvalid, // Data valid
	output logic wready, // Data taken
	// AXI4-Lite write response
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Response valid
	input wire logic bready, // Response taken
	// AXI4-Lite read address
	input wire logic [15:0] araddr, // Byte address
	input wire logic arvalid, // Address valid
	output logic arready, // Address taken
	// AXI4-Lite read data
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Data valid
	input wire logic rready, // Data taken
	// Converter samples
	input wire logic signed [SAMPLE_W-1:0] ch1Sample, // Channel 1 counts
	input wire logic ch1SampleValid, // Channel 1 strobe
	input wire logic signed [SAMPLE_W-1:0] ch2Sample, // Channel 2 counts
	input wire logic ch2SampleValid, // Channel 2 strobe
	input wire logic signed [SAMPLE_W-1:0] ch3Sample, // Channel 3 counts
	input wire logic ch3SampleValid, // Channel 3 strobe
	// Scaled results and configuration
	output logic signed [RESULT_W-1:0] ch1FreqRef, // Percent of max_output_frequency
	output logic ch1FreqRefValid, // Channel 1 result strobe
	output logic signed [RESULT_W-1:0] ch2Level, // Percent of channel 2 function
	output logic ch2LevelValid, // Channel 2 result strobe
	output logic signed [RESULT_W-1:0] ch3Level, // Percent of channel 3 function
	output logic ch3LevelValid, // Channel 3 result strobe
	output logic [4:0] ch2Function, // Channel 2 function code
	output logic [3:0] ch3Function, // Channel 3 function code
	output logic ch2CurrentMode // Channel 2 set for current input
);

	// Configuration held per channel
	ais_range_t chRange [AIS_NCH];
	logic signed [15:0] chGain [AIS_NCH];
	logic signed [15:0] chBias [AIS_NCH];
	logic [15:0] ch2FunctionSel;
	logic [15:0] ch3FunctionSel;

	// Scaler outputs
	logic signed [RESULT_W-1:0] scaled [AIS_NCH];
	logic scaledValid [AIS_NCH];
	logic signed [SAMPLE_W-1:0] samples [AIS_NCH];
	logic sampleValids [AIS_NCH];

	// Latest results for readback
	logic signed [RESULT_W-1:0] lastResult [AIS_NCH];

	// Write channel holding state
	logic awHeld;
	logic wHeld;
	logic [13:0] wrIdx;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic doWrite;
	logic [15:0] wrOld;
	logic [15:0] wrMerged;
	logic wrMapped;
	logic wrLegal;

	// Read path
	logic [13:0] rdIdx;
	logic [31:0] rdWord;
	logic rdMapped;

	assign samples[AIS_CH1] = ch1Sample;
	assign samples[AIS_CH2] = ch2Sample;
	assign samples[AIS_CH3] = ch3Sample;
	assign sampleValids[AIS_CH1] = ch1SampleValid;
	assign sampleValids[AIS_CH2] = ch2SampleValid;
	assign sampleValids[AIS_CH3] = ch3SampleValid;

	// Byte-lane merge of the low halfword; upper lanes hold no register bits
	function automatic logic [15:0] mergeHalf(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] merged;
		merged = old;
		if (strb[0])
			merged[7:0] = data[7:0];
		if (strb[1])
			merged[15:8] = data[15:8];
		return merged;
	endfunction

	// Write takes place once both address and data are held
	assign doWrite = awHeld && wHeld && !bvalid;

	// Current value of the register being written, for partial strobes
	always_comb
	begin
		wrOld = '0;
		wrMapped = 1'b1;
		unique case (wrIdx)
			AIS_IDX_CH1_RANGE: wrOld = {14'h0000, chRange[AIS_CH1]};
			AIS_IDX_CH1_GAIN: wrOld = chGain[AIS_CH1];
			AIS_IDX_CH1_BIAS: wrOld = chBias[AIS_CH1];
			AIS_IDX_CH3_RANGE: wrOld = {14'h0000, chRange[AIS_CH3]};
			AIS_IDX_CH3_FUNC: wrOld = ch3FunctionSel;
			AIS_IDX_CH3_GAIN: wrOld = chGain[AIS_CH3];
			AIS_IDX_CH3_BIAS: wrOld = chBias[AIS_CH3];
			AIS_IDX_CH2_RANGE: wrOld = {14'h0000, chRange[AIS_CH2]};
			AIS_IDX_CH2_FUNC: wrOld = ch2FunctionSel;
			AIS_IDX_CH2_GAIN: wrOld = chGain[AIS_CH2];
			AIS_IDX_CH2_BIAS: wrOld = chBias[AIS_CH2];
			default: wrMapped = 1'b0;
		endcase
	end

	assign wrMerged = mergeHalf(wrOld, wrData, wrStrb);

	// Out-of-range settings are refused whole, keeping the old value
	always_comb
	begin
		wrLegal = 1'b0;
		unique case (wrIdx)
			AIS_IDX_CH1_RANGE, AIS_IDX_CH3_RANGE:
				wrLegal = wrMerged <= 16'(AIS_RANGE_BIPOLAR);
			AIS_IDX_CH2_RANGE:
				wrLegal = wrMerged <= 16'(AIS_RANGE_CURRENT);
			AIS_IDX_CH3_FUNC:
				wrLegal = wrMerged == AIS_CH3_FUNC_A || wrMerged == AIS_CH3_FUNC_B
					|| wrMerged == AIS_CH3_FUNC_C;
			AIS_IDX_CH2_FUNC:
				wrLegal = wrMerged <= AIS_CH2_FUNC_MAX;
			AIS_IDX_CH1_GAIN, AIS_IDX_CH3_GAIN, AIS_IDX_CH2_GAIN:
				wrLegal = $signed(wrMerged) >= AIS_GAIN_MIN
					&& $signed(wrMerged) <= AIS_GAIN_MAX;
			AIS_IDX_CH1_BIAS, AIS_IDX_CH3_BIAS, AIS_IDX_CH2_BIAS:
				wrLegal = $signed(wrMerged) >= AIS_BIAS_MIN
					&& $signed(wrMerged) <= AIS_BIAS_MAX;
			default: wrLegal = 1'b0;
		endcase
	end

	// Write address and data channels, taken in either order
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			awready <= 1'b1;
			wready <= 1'b1;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wrIdx <= '0;
			wrData <= '0;
			wrStrb <= '0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awHeld <= 1'b1;
				awready <= 1'b0;
				wrIdx <= awaddr[AIS_IDX_MSB:AIS_IDX_LSB];
			end
			if (wvalid && wready)
			begin
				wHeld <= 1'b1;
				wready <= 1'b0;
				wrData <= wdata;
				wrStrb <= wstrb;
			end
			// Reopen both channels only once the response is taken
			if (bvalid && bready)
			begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Write response; refused or unmapped writes answer SLVERR
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bvalid <= 1'b0;
			bresp <= AIS_RESP_OKAY;
		end
		else if (doWrite)
		begin
			bvalid <= 1'b1;
			bresp <= (wrMapped && wrLegal) ? AIS_RESP_OKAY : AIS_RESP_SLVERR;
		end
		else if (bvalid && bready)
		begin
			bvalid <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int c = 0; c < AIS_NCH; c++)
			begin
				chRange[c] <= AIS_RANGE_UNIPOLAR;
				chGain[c] <= AIS_GAIN_RESET;
				chBias[c] <= AIS_BIAS_RESET;
			end
			ch3FunctionSel <= AIS_CH3_FUNC_RESET;
			ch2FunctionSel <= AIS_CH2_FUNC_RESET;
		end
		else if (doWrite && wrMapped && wrLegal)
		begin
			unique case (wrIdx)
				AIS_IDX_CH1_RANGE: chRange[AIS_CH1] <= ais_range_t'(wrMerged[1:0]);
				AIS_IDX_CH1_GAIN: chGain[AIS_CH1] <= wrMerged;
				AIS_IDX_CH1_BIAS: chBias[AIS_CH1] <= wrMerged;
				AIS_IDX_CH3_RANGE: chRange[AIS_CH3] <= ais_range_t'(wrMerged[1:0]);
				AIS_IDX_CH3_FUNC: ch3FunctionSel <= wrMerged;
				AIS_IDX_CH3_GAIN: chGain[AIS_CH3] <= wrMerged;
				AIS_IDX_CH3_BIAS: chBias[AIS_CH3] <= wrMerged;
				AIS_IDX_CH2_RANGE: chRange[AIS_CH2] <= ais_range_t'(wrMerged[1:0]);
				AIS_IDX_CH2_FUNC: ch2FunctionSel <= wrMerged;
				AIS_IDX_CH2_GAIN: chGain[AIS_CH2] <= wrMerged;
				AIS_IDX_CH2_BIAS: chBias[AIS_CH2] <= wrMerged;
				default: ;
			endcase
		end
	end

	// Register view of configuration for the surrounding logic
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ch2Function <= AIS_CH2_FUNC_RESET[4:0];
			ch3Function <= AIS_CH3_FUNC_RESET[3:0];
			ch2CurrentMode <= 1'b0;
		end
		else
		begin
			ch2Function <= ch2FunctionSel[4:0];
			ch3Function <= ch3FunctionSel[3:0];
			// Front end must also be switched by hand; this only reports it
			ch2CurrentMode <= chRange[AIS_CH2] == AIS_RANGE_CURRENT;
		end
	end

	// One scaler per channel
	generate
		for (genvar c = 0; c < AIS_NCH; c++)
		begin : gScale
			ais_scale_channel #(
				.SAMPLE_W(SAMPLE_W),
				.RESULT_W(RESULT_W),
				.FS_SHIFT(AIS_FS_SHIFT)
			) uScale (
				.clk(clk),
				.rst(rst),
				.sample(samples[c]),
				.sampleValid(sampleValids[c]),
				.rangeSel(chRange[c]),
				.gain(chGain[c]),
				.bias(chBias[c]),
				.result(scaled[c]),
				.resultValid(scaledValid[c])
			);
		end
	endgenerate

	// Result outputs and readback copies, refreshed on each new result
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int c = 0; c < AIS_NCH; c++)
				lastResult[c] <= '0;
			ch1FreqRefValid <= 1'b0;
			ch2LevelValid <= 1'b0;
			ch3LevelValid <= 1'b0;
		end
		else
		begin
			for (int c = 0; c < AIS_NCH; c++)
				if (scaledValid[c])
					lastResult[c] <= scaled[c];
			ch1FreqRefValid <= scaledValid[AIS_CH1];
			ch2LevelValid <= scaledValid[AIS_CH2];
			ch3LevelValid <= scaledValid[AIS_CH3];
		end
	end

	assign ch1FreqRef = lastResult[AIS_CH1];
	assign ch2Level = lastResult[AIS_CH2];
	assign ch3Level = lastResult[AIS_CH3];

	// Read decode; narrow registers sit in the low bits, upper bits zero
	assign rdIdx = araddr[AIS_IDX_MSB:AIS_IDX_LSB];

	always_comb
	begin
		rdWord = '0;
		rdMapped = 1'b1;
		unique case (rdIdx)
			AIS_IDX_CH1_RANGE: rdWord = {30'h00000000, chRange[AIS_CH1]};
			AIS_IDX_CH1_GAIN: rdWord = {16'h0000, chGain[AIS_CH1]};
			AIS_IDX_CH1_BIAS: rdWord = {16'h0000, chBias[AIS_CH1]};
			AIS_IDX_CH3_RANGE: rdWord = {30'h00000000, chRange[AIS_CH3]};
			AIS_IDX_CH3_FUNC: rdWord = {16'h0000, ch3FunctionSel};
			AIS_IDX_CH3_GAIN: rdWord = {16'h0000, chGain[AIS_CH3]};
			AIS_IDX_CH3_BIAS: rdWord = {16'h0000, chBias[AIS_CH3]};
			AIS_IDX_CH2_RANGE: rdWord = {30'h00000000, chRange[AIS_CH2]};
			AIS_IDX_CH2_FUNC: rdWord = {16'h0000, ch2FunctionSel};
			AIS_IDX_CH2_GAIN: rdWord = {16'h0000, chGain[AIS_CH2]};
			AIS_IDX_CH2_BIAS: rdWord = {16'h0000, chBias[AIS_CH2]};
			AIS_IDX_CH1_RESULT: rdWord = 32'(lastResult[AIS_CH1]);
			AIS_IDX_CH2_RESULT: rdWord = 32'(lastResult[AIS_CH2]);
			AIS_IDX_CH3_RESULT: rdWord = 32'(lastResult[AIS_CH3]);
			default: rdMapped = 1'b0;
		endcase
	end

	// Read channel; one read in flight, answered the cycle after the address
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= AIS_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rdWord;
			rresp <= rdMapped ? AIS_RESP_OKAY : AIS_RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

endmodule // ais_top

// >>> ais_pkg.sv
// Constants and types shared by the analog input scaling block.
// Assumes a 32-bit AXI4-Lite register bus; register indices are word numbers.
package ais_pkg;

	// Register indices; byte address is four times the index
	localparam logic [13:0] AIS_IDX_CH1_RANGE = 14'h0410;
	localparam logic [13:0] AIS_IDX_CH1_GAIN = 14'h0411;
	localparam logic [13:0] AIS_IDX_CH1_BIAS = 14'h0412;
	localparam logic [13:0] AIS_IDX_CH3_RANGE = 14'h0413;
	localparam logic [13:0] AIS_IDX_CH3_FUNC = 14'h0414;
	localparam logic [13:0] AIS_IDX_CH3_GAIN = 14'h0415;
	localparam logic [13:0] AIS_IDX_CH3_BIAS = 14'h0416;
	localparam logic [13:0] AIS_IDX_CH2_RANGE = 14'h0417;
	localparam logic [13:0] AIS_IDX_CH2_FUNC = 14'h0418;
	localparam logic [13:0] AIS_IDX_CH2_GAIN = 14'h0419;
	localparam logic [13:0] AIS_IDX_CH2_BIAS = 14'h041A;
	// Read-only readback of the latest scaled results
	localparam logic [13:0] AIS_IDX_CH1_RESULT = 14'h0420;
	localparam logic [13:0] AIS_IDX_CH2_RESULT = 14'h0421;
	localparam logic [13:0] AIS_IDX_CH3_RESULT = 14'h0422;

	// Word index taken from the byte address
	localparam int AIS_IDX_LSB = 2;
	localparam int AIS_IDX_MSB = 15;

	// Channel slots in the per-channel arrays
	localparam int AIS_CH1 = 0;
	localparam int AIS_CH2 = 1;
	localparam int AIS_CH3 = 2;
	localparam int AIS_NCH = 3;

	// Signal range codes
	typedef enum logic [1:0]
	{
		AIS_RANGE_UNIPOLAR = 2'b00,
		AIS_RANGE_BIPOLAR = 2'b01,
		AIS_RANGE_CURRENT = 2'b10
	} ais_range_t;

	// Gain and bias in 0.1 % steps, signed 16 bits
	localparam logic signed [15:0] AIS_GAIN_MIN = 16'sh0000;
	localparam logic signed [15:0] AIS_GAIN_MAX = 16'sh2710;
	localparam logic signed [15:0] AIS_GAIN_RESET = 16'sh03E8;
	localparam logic signed [15:0] AIS_BIAS_MIN = -16'sh03E8;
	localparam logic signed [15:0] AIS_BIAS_MAX = 16'sh03E8;
	localparam logic signed [15:0] AIS_BIAS_RESET = 16'sh0000;

	// Function selection codes
	localparam logic [15:0] AIS_CH3_FUNC_A = 16'h0002;
	localparam logic [15:0] AIS_CH3_FUNC_B = 16'h0003;
	localparam logic [15:0] AIS_CH3_FUNC_C = 16'h000E;
	localparam logic [15:0] AIS_CH3_FUNC_RESET = 16'h0002;
	localparam logic [15:0] AIS_CH2_FUNC_MAX = 16'h001F;
	localparam logic [15:0] AIS_CH2_FUNC_RESET = 16'h0003;
	localparam logic [15:0] AIS_RANGE_RESET = 16'h0000;

	// Converter full scale (10 V or 20 mA) as a power of two in counts
	localparam int AIS_FS_SHIFT = 12;

	// AXI4-Lite response codes
	localparam logic [1:0] AIS_RESP_OKAY = 2'b00;
	localparam logic [1:0] AIS_RESP_SLVERR = 2'b10;

endpackage

// >>> ais_scale_channel.sv
// One channel of linear scaling from converter counts to percent of function.
// Assumes samples arrive on clk from converter logic in the same domain.
`timescale 1ns/10ps
module ais_scale_channel
	import ais_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int RESULT_W = 32,
	parameter int FS_SHIFT = AIS_FS_SHIFT
)
(
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, active high
	input wire logic signed [SAMPLE_W-1:0] sample, // Converter counts
	input wire logic sampleValid, // Sample strobe
	input wire ais_range_t rangeSel, // Signal range of this channel
	input wire logic signed [15:0] gain, // Level at full-scale input
	input wire logic signed [15:0] bias, // Level at zero input
	output logic signed [RESULT_W-1:0] result, // Scaled level, 0.1 % steps
	output logic resultValid // Result strobe
);

	localparam int PROD_W = SAMPLE_W + 17;

	logic signed [16:0] span;
	logic signed [SAMPLE_W-1:0] clampSample;
	logic signed [PROD_W-1:0] product;
	logic signed [PROD_W-1:0] shifted;
	logic signed [15:0] biasHeld;
	logic productValid;

	// Slope between the zero point and the full-scale point
	assign span = {gain[15], gain} - {bias[15], bias};

	// Unipolar and current inputs cannot go below zero; bipolar extrapolates
	always_comb
	begin
		clampSample = sample;
		if (rangeSel != AIS_RANGE_BIPOLAR && sample < 0)
			clampSample = '0;
	end

	// Stage one: product of slope and sample
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			product <= '0;
			biasHeld <= '0;
			productValid <= 1'b0;
		end
		else
		begin
			product <= span * clampSample;
			biasHeld <= bias;
			productValid <= sampleValid;
		end
	end

	assign shifted = product >>> FS_SHIFT;

	// Stage two: offset by the bias point
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			result <= '0;
			resultValid <= 1'b0;
		end
		else
		begin
			result <= shifted[RESULT_W-1:0] + {{(RESULT_W-16){biasHeld[15]}}, biasHeld};
			resultValid <= productValid;
		end
	end

endmodule // ais_scale_channel

// >>> ais_props.sv
// Checker for the analog input scaling top: result timing and config outputs.
// Assumes it is bound to ais_top and sees only that module's ports.
`timescale 1ns/10ps
module ais_props
	import ais_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, active high
	input wire logic bvalid, // Write response valid
	input wire logic ch1SampleValid, // Ch1 sample strobe
	input wire logic ch2SampleValid, // Ch2 sample strobe
	input wire logic ch3SampleValid, // Ch3 sample strobe
	input wire logic ch1FreqRefValid, // Ch1 result strobe
	input wire logic ch2LevelValid, // Ch2 result strobe
	input wire logic ch3LevelValid, // Ch3 result strobe
	input wire logic [4:0] ch2Function, // Ch2 function code
	input wire logic [3:0] ch3Function, // Ch3 function code
	input wire logic ch2CurrentMode // Ch2 current input
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);

	// Every sample gives exactly one result, three edges later
	a_ch1_delay: assert property (ch1SampleValid |-> ##3 ch1FreqRefValid)
		else $error("ch1 result late or missing");
	a_ch1_cause: assert property (ch1FreqRefValid |-> $past(ch1SampleValid, 3))
		else $error("ch1 result without sample");
	a_ch2_delay: assert property (ch2SampleValid |-> ##3 ch2LevelValid)
		else $error("ch2 result late or missing");
	a_ch2_cause: assert property (ch2LevelValid |-> $past(ch2SampleValid, 3))
		else $error("ch2 result without sample");
	a_ch3_delay: assert property (ch3SampleValid |-> ##3 ch3LevelValid)
		else $error("ch3 result late or missing");
	a_ch3_cause: assert property (ch3LevelValid |-> $past(ch3SampleValid, 3))
		else $error("ch3 result without sample");
	// Ch3 function code only ever holds legal values; ch2 code moves only with a write
	a_ch3_func_legal: assert property (ch3Function inside {4'h2, 4'h3, 4'hE})
		else $error("ch3 function code illegal");
	// Output view lags the register by one edge, so the response rose two edges back
	a_ch2_func_write: assert property ($changed(ch2Function) |-> $past(bvalid) && !$past(bvalid, 2))
		else $error("ch2 function changed without write");
	a_cur_mode_write: assert property ($changed(ch2CurrentMode) |-> $past(bvalid) && !$past(bvalid, 2))
		else $error("ch2 current mode changed without write");
endmodule // ais_props

bind ais_top ais_props ais_props_i (.clk(clk), .rst(rst), .bvalid(bvalid),
	.ch1SampleValid(ch1SampleValid), .ch2SampleValid(ch2SampleValid),
	.ch3SampleValid(ch3SampleValid), .ch1FreqRefValid(ch1FreqRefValid),
	.ch2LevelValid(ch2LevelValid), .ch3LevelValid(ch3LevelValid),
	.ch2Function(ch2Function), .ch3Function(ch3Function), .ch2CurrentMode(ch2CurrentMode));

// >>> ais_source_model.sv
// Behavioural converter feeding one analog channel with single samples.
// Assumes the bench pulses go for one cycle and holds level until delivery.
`timescale 1ns/10ps
module ais_source_model
(
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, active high
	input wire logic go, // Start one conversion
	input wire logic [3:0] gap, // Extra conversion delay in cycles
	input wire logic [15:0] level, // Counts to deliver
	output logic [15:0] sample, // Converter counts
	output logic sampleValid // One-cycle strobe
);
	logic [4:0] cnt;

	// Conversion timer; data line toggles outside a delivery so stale data is not reused
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt <= 5'h00;
			sampleValid <= 1'b0;
			sample <= 16'h0000;
		end
		else
		begin
			sampleValid <= 1'b0;
			sample <= ~sample;
			if (go)
				cnt <= {1'b0, gap} + 5'h01;
			else if (cnt != 5'h00)
				cnt <= cnt - 5'h01;
			if (cnt == 5'h01)
			begin
				sample <= level;
				sampleValid <= 1'b1;
			end
		end
	end
endmodule // ais_source_model

// >>> tb_top.sv
// Self-checking bench for ais_top: register map over AXI4-Lite and scaling.
// Assumes ais_props is bound by its own file and three source models drive samples.
`timescale 1ns/10ps
module tb_top
	import ais_pkg::*;
;
	typedef struct packed {logic [13:0] idx; logic [31:0] wd; logic [1:0] wr; logic [31:0] rd;} ais_row_t;
	localparam logic [1:0] OK = AIS_RESP_OKAY;
	localparam logic [1:0] ER = AIS_RESP_SLVERR;
	// Write value, expected response, expected readback
	localparam ais_row_t ROWS [19] = '{
		'{AIS_IDX_CH1_RANGE, 32'h1, OK, 32'h1}, '{AIS_IDX_CH1_RANGE, 32'h2, ER, 32'h1},
		'{AIS_IDX_CH1_GAIN, 32'h2710, OK, 32'h2710}, '{AIS_IDX_CH1_GAIN, 32'h2711, ER, 32'h2710},
		'{AIS_IDX_CH1_BIAS, 32'hFC18, OK, 32'hFC18}, '{AIS_IDX_CH1_BIAS, 32'h3E9, ER, 32'hFC18},
		'{AIS_IDX_CH3_RANGE, 32'h1, OK, 32'h1}, '{AIS_IDX_CH3_RANGE, 32'h2, ER, 32'h1},
		'{AIS_IDX_CH3_FUNC, 32'hE, OK, 32'hE}, '{AIS_IDX_CH3_FUNC, 32'h3, OK, 32'h3},
		'{AIS_IDX_CH3_FUNC, 32'h4, ER, 32'h3},
		'{AIS_IDX_CH3_GAIN, 32'h0, OK, 32'h0}, '{AIS_IDX_CH3_BIAS, 32'h3E8, OK, 32'h3E8},
		'{AIS_IDX_CH2_RANGE, 32'h2, OK, 32'h2}, '{AIS_IDX_CH2_RANGE, 32'h3, ER, 32'h2},
		'{AIS_IDX_CH2_FUNC, 32'h1F, OK, 32'h1F}, '{AIS_IDX_CH2_FUNC, 32'h20, ER, 32'h1F},
		'{AIS_IDX_CH2_GAIN, 32'h1F4, OK, 32'h1F4}, '{AIS_IDX_CH2_BIAS, 32'hFF9C, OK, 32'hFF9C}};
	localparam logic [15:0] RSTV [11] = '{16'h0, 16'h3E8, 16'h0, 16'h0, 16'h2, 16'h3E8, 16'h0,
		16'h0, 16'h3, 16'h3E8, 16'h0};
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, d;
	logic [3:0] wstrb, gap;
	logic [2:0] go;
	logic [15:0] lvl [3];
	logic [1:0] r;
	int i, n_fail, total_checks;
	wire logic awready, wready, bvalid, arready, rvalid, ch2CurrentMode;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [4:0] ch2Function;
	wire logic [3:0] ch3Function;
	wire logic [2:0] smpV, resV;
	wire logic [15:0] smp [3];
	wire logic [31:0] res [3];

	ais_top ais_top_i (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ch1Sample(smp[0]), .ch1SampleValid(smpV[0]), .ch2Sample(smp[1]), .ch2SampleValid(smpV[1]),
		.ch3Sample(smp[2]), .ch3SampleValid(smpV[2]), .ch1FreqRef(res[0]),
		.ch1FreqRefValid(resV[0]), .ch2Level(res[1]), .ch2LevelValid(resV[1]), .ch3Level(res[2]),
		.ch3LevelValid(resV[2]), .ch2Function(ch2Function), .ch3Function(ch3Function),
		.ch2CurrentMode(ch2CurrentMode));

	// One converter per channel
	for (genvar k = 0; k < 3; k++)
	begin : g_src
		ais_source_model ais_source_model_i (.clk(clk), .rst(rst), .go(go[k]), .gap(gap), .level(lvl[k]),
			.sample(smp[k]), .sampleValid(smpV[k]));
	end

	// 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever
			#25 clk = ~clk;
	end

	task automatic stop_test();
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask

	// Ready is a register, so its level at the falling edge is what the next rising edge takes
	task automatic wr(input logic [13:0] idx, input logic [31:0] dat, output logic [1:0] rsp);
		int n;
		logic aw, w, b;
		b = 1'b0;
		awaddr <= {idx, 2'b00};
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40 && !b; n++)
		begin
			@(negedge clk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			rsp = bresp;
			@(posedge clk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!b)
		begin
			check("write answer", 32'h1, 32'h0);
			stop_test();
		end
		// One edge between calls, so a next call never re-drives bready in this step
		@(posedge clk);
	endtask

	task automatic rd(input logic [13:0] idx, output logic [31:0] dat, output logic [1:0] rsp);
		int n;
		logic ar, v;
		v = 1'b0;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40 && !v; n++)
		begin
			@(negedge clk);
			ar = arvalid && arready;
			v = rvalid;
			dat = rdata;
			rsp = rresp;
			@(posedge clk);
			if (ar)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!v)
		begin
			check("read answer", 32'h1, 32'h0);
			stop_test();
		end
		// One edge between calls, so a next call never re-drives rready in this step
		@(posedge clk);
	endtask

	// One sample through a channel, result compared when its strobe shows
	task automatic conv(input int ch, input logic [15:0] s, input logic [3:0] g, input logic [31:0] e);
		int n;
		logic v;
		v = 1'b0;
		lvl[ch] <= s;
		gap <= g;
		go[ch] <= 1'b1;
		@(posedge clk);
		go[ch] <= 1'b0;
		for (n = 0; n < 40 && !v; n++)
		begin
			@(negedge clk);
			v = resV[ch];
			if (v)
				check("scaled result", e, res[ch]);
			@(posedge clk);
		end
		if (!v)
		begin
			check("result strobe", 32'h1, 32'h0);
			stop_test();
		end
	endtask

	// Main sequence
	initial
	begin
		{n_fail, total_checks} = '0;
		{rst, awvalid, wvalid, bready, arvalid, rready, go, gap} = {1'b1, 12'h000};
		{awaddr, araddr, wdata, wstrb} = {16'h0000, 16'h0000, 32'h0, 4'hF};
		{lvl[0], lvl[1], lvl[2]} = '0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 19; i++)
		begin
			wr(ROWS[i].idx, ROWS[i].wd, r);
			check("bresp", 32'(ROWS[i].wr), 32'(r));
			rd(ROWS[i].idx, d, r);
			check("readback", ROWS[i].rd, d);
		end
		check("current mode", 32'h1, 32'(ch2CurrentMode));
		check("ch2 function", 32'h1F, 32'(ch2Function));
		check("ch3 function", 32'h3, 32'(ch3Function));
		conv(0, 16'h0800, 4'h0, 32'h00001194);
		conv(0, 16'hFE67, 4'h3, 32'hFFFFF7CD);
		// Source delivers current counts, front end taken as switched to current
		conv(1, 16'h1000, 4'h5, 32'h000001F4);
		conv(1, 16'hFF9C, 4'h0, 32'hFFFFFF9C);
		conv(2, 16'hF000, 4'h0, 32'h000007D0);
		rd(AIS_IDX_CH1_RESULT, d, r);
		check("result readback", 32'hFFFFF7CD, d);
		wr(AIS_IDX_CH1_RESULT, 32'h0, r);
		check("result write bresp", 32'(ER), 32'(r));
		wr(14'h0430, 32'h5, r);
		check("unmapped bresp", 32'(ER), 32'(r));
		rd(14'h0430, d, r);
		check("unmapped rresp", 32'(ER), 32'(r));
		// Second reset in mid-run restores every setting
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		check("reset ch2 function", 32'h3, 32'(ch2Function));
		check("reset ch3 function", 32'h2, 32'(ch3Function));
		check("reset current mode", 32'h0, 32'(ch2CurrentMode));
		rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 11; i++)
		begin
			rd(AIS_IDX_CH1_RANGE + 14'(i), d, r);
			check("reset value", 32'(RSTV[i]), d);
		end
		// Low byte lane only: the upper byte of the reset gain must survive
		wstrb <= 4'h1;
		wr(AIS_IDX_CH2_GAIN, 32'h000012AB, r);
		check("strobe bresp", 32'(OK), 32'(r));
		wstrb <= 4'hF;
		rd(AIS_IDX_CH2_GAIN, d, r);
		check("strobe merge", 32'h000003AB, d);
		conv(0, 16'h0800, 4'h0, 32'h000001F4);
		conv(0, 16'hF800, 4'h0, 32'h00000000);
		stop_test();
	end
endmodule // tb_top
